// file: rtl/fep_pkg.sv
/*
  fep_pkg: constants for the flash / serial prom local memory port.
  assumes a 20 MHz system clock and a 2.5 MHz link clock sampled as a plain input.
*/
package fep_pkg;
  localparam int         ADDR_W          = 17;
  localparam int         DATA_W          = 8;
  // ----------------------------------------
  // pin positions of the shared address bus
  // ----------------------------------------
  localparam int         PIN_POWER       = 1;
  localparam int         PIN_STRAP       = 7;
  localparam int         PIN_PROM_DI     = 13;
  localparam int         PIN_PROM_DO     = 14;
  localparam int         PIN_PROM_SK     = 15;
  localparam int         PIN_TOP         = 16;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_HZ          = 20_000_000;
  localparam int         STROBE_NS       = 150;
  localparam int         STROBE_CYC      = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int         PROM_HALF_NS    = 500;
  localparam int         PROM_HALF_CYC   = (PROM_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] CNT_RST         = 4'h0;
  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    FEP_IDLE  = 3'h0,
    FEP_SETUP = 3'h1,
    FEP_STRB  = 3'h3,
    FEP_DONE  = 3'h2,
    FEP_PLO   = 3'h6,
    FEP_PHI   = 3'h7
  } fep_state_e;
endpackage

// file: rtl/fep_local_port.sv
/*
  fep_local_port: sequencer for a byte-wide parallel flash and a four-wire
  serial prom sharing address pins. assumes the user holds requests until done,
  and that the 2.5 MHz link clock comes from outside and is sampled here.
*/
`timescale 1ns/100ps
// Summary of operation
// - seventeen address outputs cover 128 Kbyte flash when strap low
// - data bus released unless writing a byte
// - top pin carries clock when strap high
// - pin 7 sampled as strap during reset
// - pin 15 is prom shift clock
// - pin 14 receives prom data when serial
// - pin 13 drives prom data input
// - pin 1 sampled as power source in reset
// - pin 0 driven as lowest address bit
// - separate prom select frames each run of bits up to the last
// - flash select low only during flash access
// - read strobe low during read cycles
// - write strobe low while driving write byte
module fep_local_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        aux_clock_in,
  input  wire logic        flash_req,
  input  wire logic        flash_we,
  input  wire logic [16:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  output logic      [7:0]  flash_rdata,
  input  wire logic        prom_req,
  input  wire logic        prom_bit_out,
  input  wire logic        prom_last,
  output logic             prom_bit_in,
  output logic             done,
  output logic             aux_clock_strap,
  output logic             power_source_strap,
  output logic [16:0]      flash_address_bus_o,
  output logic [16:0]      flash_address_bus_oe,
  input  wire logic [16:0] flash_address_bus_i,
  output logic [7:0]       flash_data_bus_o,
  output logic             flash_data_bus_oe,
  input  wire logic [7:0]  flash_data_bus_i,
  output logic             serial_prom_select,
  output logic             parallel_mem_select_n,
  output logic             parallel_mem_read_strobe_n,
  output logic             parallel_mem_write_strobe_n
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [16:0]           pin_s1_ff;
  logic [16:0]           pin_s2_ff;
  logic [7:0]            dat_s1_ff;
  logic [7:0]            dat_s2_ff;
  logic [2:0]            ck_sync_ff;
  fep_pkg::fep_state_e   state_ff;
  logic [3:0]            cnt_ff;
  logic                  is_prom_ff;
  logic                  is_write_ff;
  logic                  last_ff;
  logic [16:0]           addr_ff;
  logic                  strap_ff;

  always_ff @(posedge clk) begin
    pin_s1_ff <= flash_address_bus_i;
    pin_s2_ff <= pin_s1_ff;
    dat_s1_ff <= flash_data_bus_i;
    dat_s2_ff <= dat_s1_ff;
    ck_sync_ff <= {ck_sync_ff[1:0], aux_clock_in};
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // reset delayed to match the pin synchroniser, so the samples kept are
  // the next-to-last ones taken while pins 7 and 1 were released
  logic                  rst_d1_ff;
  logic                  rst_d2_ff;

  always_ff @(posedge clk) begin
    rst_d1_ff <= srst;
    rst_d2_ff <= rst_d1_ff;
  end

  // limitation: straps read valid only two cycles after reset ends
  always_ff @(posedge clk) begin
    if (rst_d2_ff) begin
      strap_ff           <= pin_s2_ff[fep_pkg::PIN_STRAP];
      power_source_strap <= pin_s2_ff[fep_pkg::PIN_POWER];
    end
  end
  assign aux_clock_strap = strap_ff;

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  // one sequencer for both kinds keeps the shared pins single-owner
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff    <= fep_pkg::FEP_IDLE;
      cnt_ff      <= fep_pkg::CNT_RST;
      is_prom_ff  <= 1'b0;
      is_write_ff <= 1'b0;
      last_ff     <= 1'b0;
      addr_ff     <= '0;
      done        <= 1'b0;
      flash_rdata <= 8'h00;
      prom_bit_in <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_ff)
        fep_pkg::FEP_IDLE: begin
          if (flash_req) begin
            is_prom_ff  <= 1'b0;
            is_write_ff <= flash_we;
            addr_ff     <= flash_addr;
            state_ff    <= fep_pkg::FEP_SETUP;
          end else if (prom_req) begin
            is_prom_ff <= 1'b1;
            last_ff    <= prom_last;
            cnt_ff     <= fep_pkg::CNT_RST;
            state_ff   <= fep_pkg::FEP_PLO;
          end
        end
        fep_pkg::FEP_SETUP: begin
          cnt_ff   <= fep_pkg::CNT_RST;
          state_ff <= fep_pkg::FEP_STRB;
        end
        fep_pkg::FEP_STRB: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'(fep_pkg::STROBE_CYC - 1)) begin
            state_ff <= fep_pkg::FEP_DONE;
          end
        end
        // read byte taken one cycle late: the synchroniser holds the data
        // from two edges back, the first strobe-low sample lands here
        fep_pkg::FEP_DONE: begin
          if (!is_write_ff) begin
            flash_rdata <= dat_s2_ff;
          end
          done     <= 1'b1;
          state_ff <= fep_pkg::FEP_IDLE;
        end
        fep_pkg::FEP_PLO: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'(fep_pkg::PROM_HALF_CYC - 1)) begin
            cnt_ff   <= fep_pkg::CNT_RST;
            state_ff <= fep_pkg::FEP_PHI;
          end
        end
        fep_pkg::FEP_PHI: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'(fep_pkg::PROM_HALF_CYC - 1)) begin
            prom_bit_in <= pin_s2_ff[fep_pkg::PIN_PROM_DO];
            done        <= 1'b1;
            state_ff    <= fep_pkg::FEP_IDLE;
          end
        end
        default: state_ff <= fep_pkg::FEP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // prom select holds between bits until the last bit ends the frame
  logic sel_hold_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_hold_ff <= 1'b0;
    end else if (state_ff == fep_pkg::FEP_PHI && done == 1'b0 &&
                 cnt_ff == 4'(fep_pkg::PROM_HALF_CYC - 1)) begin
      sel_hold_ff <= ~last_ff;
    end else if (state_ff != fep_pkg::FEP_IDLE && !is_prom_ff) begin
      sel_hold_ff <= 1'b0;
    end
  end

  logic flash_act;
  logic prom_act;
  assign flash_act = (state_ff == fep_pkg::FEP_SETUP) || (state_ff == fep_pkg::FEP_STRB) ||
                     (state_ff == fep_pkg::FEP_DONE);
  assign prom_act  = (state_ff == fep_pkg::FEP_PLO) || (state_ff == fep_pkg::FEP_PHI);

  // an open frame holds the prom pins between bits with the shift clock low;
  // a flash access closes it at once rather than overlap the selects
  logic prom_frame;
  assign prom_frame = prom_act || (sel_hold_ff && !flash_act);

  always_ff @(posedge clk) begin
    if (srst) begin
      flash_address_bus_oe        <= '0;
      flash_address_bus_o         <= '0;
      flash_data_bus_oe           <= 1'b0;
      flash_data_bus_o            <= 8'h00;
      serial_prom_select          <= 1'b0;
      parallel_mem_select_n       <= 1'b1;
      parallel_mem_read_strobe_n  <= 1'b1;
      parallel_mem_write_strobe_n <= 1'b1;
    end else begin
      // pins 7 and 1 released during reset so straps can be read; driven after
      flash_address_bus_oe <= '1;
      flash_address_bus_oe[fep_pkg::PIN_PROM_DO] <= ~prom_frame;
      flash_address_bus_o  <= addr_ff;
      if (prom_frame) begin
        flash_address_bus_o[fep_pkg::PIN_PROM_SK] <= (state_ff == fep_pkg::FEP_PHI);
        flash_address_bus_o[fep_pkg::PIN_PROM_DI] <= prom_bit_out;
      end
      if (strap_ff) begin
        flash_address_bus_o[fep_pkg::PIN_TOP] <= ck_sync_ff[2];
      end
      serial_prom_select    <= prom_frame;
      parallel_mem_select_n <= ~flash_act;
      parallel_mem_read_strobe_n  <= ~(state_ff == fep_pkg::FEP_STRB && !is_write_ff);
      parallel_mem_write_strobe_n <= ~(state_ff == fep_pkg::FEP_STRB && is_write_ff);
      flash_data_bus_oe <= flash_act && is_write_ff;
      flash_data_bus_o  <= flash_wdata;
    end
  end
endmodule

// file: test/fep_properties.sv
/* checker for the flash / serial prom port.
   sees only the top ports; bound by name after the module. */
`timescale 1ns/100ps
module fep_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [16:0] flash_addr,
  input wire logic        prom_bit_out,
  input wire logic        done,
  input wire logic [16:0] flash_address_bus_o,
  input wire logic [16:0] flash_address_bus_oe,
  input wire logic        flash_data_bus_oe,
  input wire logic        serial_prom_select,
  input wire logic        parallel_mem_select_n,
  input wire logic        parallel_mem_read_strobe_n,
  input wire logic        parallel_mem_write_strobe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_NO_OVERLAP: assert property (!(serial_prom_select && !parallel_mem_select_n))
    else $error("both selects active");
  AST_RD_IN_SEL: assert property (!parallel_mem_read_strobe_n |->
    !parallel_mem_select_n && !flash_data_bus_oe) else $error("read strobe misplaced");
  AST_WR_DRIVES: assert property (!parallel_mem_write_strobe_n |->
    flash_data_bus_oe && !parallel_mem_select_n) else $error("write strobe without data");
  AST_DATA_REL: assert property (flash_data_bus_oe |-> !parallel_mem_select_n)
    else $error("data bus driven outside access");
  AST_RD_LEN: assert property ($fell(parallel_mem_read_strobe_n) |=>
    !parallel_mem_read_strobe_n[*2] ##1 parallel_mem_read_strobe_n) else $error("read len");
  AST_WR_LEN: assert property ($fell(parallel_mem_write_strobe_n) |=>
    !parallel_mem_write_strobe_n[*2] ##1 parallel_mem_write_strobe_n) else $error("write len");
  // first strobe cycle only: the user may move the address once done has pulsed
  AST_ADDR_OUT: assert property ($fell(parallel_mem_read_strobe_n) ||
    $fell(parallel_mem_write_strobe_n) |-> flash_address_bus_oe[15:0] == 16'hffff &&
    flash_address_bus_o[15:0] == flash_addr[15:0]) else $error("address pins wrong");
  AST_PROM_PINS: assert property (serial_prom_select && flash_address_bus_o[15] |->
    !flash_address_bus_oe[14] && flash_address_bus_o[13] == prom_bit_out) else $error("prom pins");
  AST_DONE_PULSE: assert property (done |=> !done) else $error("done longer than one cycle");
endmodule
bind fep_local_port fep_props CHK (.*);

// file: test/fep_mem_model.sv
/* flash, serial prom and board straps beside the port.
   assumes split pins; resolves every shared wire for the port's inputs. */
`timescale 1ns/100ps
module fep_mem_model (
  input  wire logic        clk,
  input  wire logic        clk_strap_pin,
  input  wire logic        pwr_strap_pin,
  input  wire logic [16:0] flash_address_bus_o,
  input  wire logic [16:0] flash_address_bus_oe,
  input  wire logic [7:0]  flash_data_bus_o,
  input  wire logic        flash_data_bus_oe,
  input  wire logic        serial_prom_select,
  input  wire logic        parallel_mem_select_n,
  input  wire logic        parallel_mem_read_strobe_n,
  input  wire logic        parallel_mem_write_strobe_n,
  output logic      [16:0] flash_address_bus_i,
  output logic      [7:0]  flash_data_bus_i
);
  logic [7:0] mem [logic [16:0]];
  logic [7:0] last_d = 8'h00;
  logic       prom_q = 1'b0;
  logic [16:0] mem_a;
  // pin 16 carries the clock in that mode, so only 64 Kbyte is reached
  assign mem_a = {flash_address_bus_o[16] & ~clk_strap_pin, flash_address_bus_o[15:0]};
  always @(negedge clk) begin
    if (!parallel_mem_write_strobe_n && !parallel_mem_select_n && flash_data_bus_oe)
      mem[mem_a] = flash_data_bus_o;
    if (serial_prom_select && flash_address_bus_o[15])
      prom_q <= ~flash_address_bus_o[13];
    last_d <= flash_data_bus_i;
  end
  // undriven pins show the inverse, so a stale value never passes
  always_comb begin
    flash_address_bus_i = ~(flash_address_bus_o ^ flash_address_bus_oe);
    if (!flash_address_bus_oe[1]) flash_address_bus_i[1] = pwr_strap_pin;
    if (!flash_address_bus_oe[7]) flash_address_bus_i[7] = clk_strap_pin;
    if (!flash_address_bus_oe[14] && serial_prom_select) flash_address_bus_i[14] = prom_q;
    flash_data_bus_i = flash_data_bus_oe ? flash_data_bus_o : ~last_d;
    if (!flash_data_bus_oe && !parallel_mem_select_n && !parallel_mem_read_strobe_n)
      flash_data_bus_i = mem[mem_a];
  end
endmodule

// file: test/fep_local_port_bench.sv
/* bench for the flash / serial prom port: straps, flash cycles, prom frame, clock pin.
   inputs move at the falling edge; the memory model answers on the pins. */
`timescale 1ns/100ps
module fep_local_port_bench;
  logic clk = 1'b0, srst = 1'b1, aux_clock_in = 1'b0, flash_req = 1'b0, flash_we = 1'b0;
  logic prom_req = 1'b0, prom_bit_out = 1'b0, prom_last = 1'b0;
  logic clk_strap_pin = 1'b1, pwr_strap_pin = 1'b0;
  logic [16:0] flash_addr = 17'h0, flash_address_bus_o, flash_address_bus_oe, flash_address_bus_i;
  logic [7:0] flash_wdata = 8'h0, flash_rdata, flash_data_bus_o, flash_data_bus_i;
  logic prom_bit_in, done, aux_clock_strap, power_source_strap, flash_data_bus_oe;
  logic serial_prom_select, parallel_mem_select_n, parallel_mem_read_strobe_n;
  logic parallel_mem_write_strobe_n;
  int num_errors = 0, check_count = 0;
  initial forever #25 clk = ~clk;
  initial forever #200 aux_clock_in = ~aux_clock_in;
  fep_local_port DUT (.*);
  fep_mem_model MEM (.*);
  task automatic chk(string nm, logic [16:0] exp, logic [16:0] got);
    check_count++;
    if (exp !== got) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 40);
    if (n >= 40) num_errors++;
  endtask
  task automatic flash_op(logic we, logic [16:0] a, logic [7:0] wd, logic [7:0] exp);
    flash_we = we; flash_addr = a; flash_wdata = wd; flash_req = 1'b1;
    wait_done();
    flash_req = 1'b0;
    if (!we) chk("flash_rdata", 17'(exp), 17'(flash_rdata));
    @(negedge clk);
  endtask
  task automatic prom_op(logic b, logic last);
    prom_bit_out = b; prom_last = last; prom_req = 1'b1;
    wait_done();
    prom_req = 1'b0;
    chk("prom_bit_in", 17'(!b), 17'(prom_bit_in));
    repeat (2) @(negedge clk);
    chk("serial_prom_select", 17'(!last), 17'(serial_prom_select));
  endtask
  // window starts 100 ns after a low edge so the sync lag cannot move a rise across it
  task automatic t_clock();
    int rises;
    logic prev;
    rises = 0;
    @(negedge aux_clock_in);
    #100;
    prev = flash_address_bus_o[16];
    repeat (82) begin
      @(negedge clk);
      if (flash_address_bus_o[16] && !prev) rises++;
      prev = flash_address_bus_o[16];
    end
    chk("clock pin rises", 17'h0000a, 17'(rises));
  endtask
  // second reset with the other strap levels: pin 16 is address bit 16 again
  task automatic t_restrap();
    srst = 1'b1;
    clk_strap_pin = 1'b0;
    pwr_strap_pin = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("aux_clock_strap", 17'h0, 17'(aux_clock_strap));
    chk("power_source_strap", 17'h1, 17'(power_source_strap));
    flash_op(1'b1, 17'h1ffff, 8'h3c, 8'h00);
    flash_op(1'b0, 17'h1ffff, 8'h00, 8'h3c);
    chk("pin 16 address", 17'h1, 17'(flash_address_bus_o[16]));
    flash_op(1'b0, 17'h0ffff, 8'h00, 8'ha5);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("aux_clock_strap", 17'h1, 17'(aux_clock_strap));
    chk("power_source_strap", 17'h0, 17'(power_source_strap));
    flash_op(1'b1, 17'h1ffff, 8'ha5, 8'h00);
    flash_op(1'b1, 17'h00000, 8'h5a, 8'h00);
    flash_op(1'b0, 17'h1ffff, 8'h00, 8'ha5);
    prom_op(1'b1, 1'b0);
    prom_op(1'b0, 1'b0);
    prom_op(1'b1, 1'b1);
    prom_op(1'b0, 1'b0);
    flash_op(1'b0, 17'h00000, 8'h00, 8'h5a);
    t_clock();
    t_restrap();
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
